// >>> common/clk_src_pkg.sv
// constants and types for the input clock source controller
// assumes one clock (core_clk) and an axi4-lite register slave
package clk_src_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] MULT_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;

  // control register fields
  localparam int CTRL_PLL_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;

  // status register fields
  localparam int STAT_SRC_BIT = 0;
  localparam int STAT_STABLE_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_DOWN_BIT = 3;
  localparam int STAT_IDLE_BIT = 4;

  // field widths, reset values and the multiplier minimum
  localparam int DIV_W = 5;
  localparam int MULT_W = 4;
  localparam logic [4:0] DIV_RST = 5'h00;
  localparam logic [3:0] MULT_MIN = 4'h2;
  localparam logic [3:0] MULT_RST = 4'h2;

  // stabilization count in reference clock edges
  localparam int STAB_W = 16;
  localparam int unsigned STAB_CYCLES_DEF = 41032;

  // strap settle wait, cycles of core_clk after reset
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_BOOT,
    ST_RUN,
    ST_ASLEEP,
    ST_RELOAD,
    ST_WAKE
  } src_state_e;

endpackage

// >>> common/ref_edge_if.sv
// carries reference edge events and the stabilization handshake
// assumes all signals are on core_clk
interface ref_edge_if;
  logic edge_rise;
  logic edge_any;
  logic reload;
  logic stable;

  modport ctrl (output edge_rise, output edge_any, output reload, input stable);
  modport stab (input edge_rise, input reload, output stable);
  modport div (input edge_any);
endinterface

// >>> verilog/stab_counter.sv
// stabilization down-counter on reference clock rising edges
// assumes edge pulses are one core_clk cycle wide
module stab_counter
  import clk_src_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // edge events and handshake
  ref_edge_if.stab edges
);

  typedef struct packed {
    logic [STAB_W-1:0] cnt;
    logic stable;
  } stab_s;

  localparam logic [STAB_W-1:0] LOAD = STAB_W'(STAB_CYCLES);

  stab_s r;
  stab_s n;

  // reload on event, count down on edges, stable at zero
  always_comb begin
    n = r;
    if (edges.reload) begin
      n.cnt = LOAD;
      n.stable = 1'b0;
    end else if (r.cnt != '0) begin
      if (edges.edge_rise) begin
        n.cnt = r.cnt - 1'b1;
      end
      n.stable = 1'b0;
    end else begin
      n.stable = 1'b1;
    end
  end

  // state register, count armed from reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{cnt: LOAD, stable: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign edges.stable = r.stable;

endmodule

// >>> verilog/ref_divider.sv
// prescale divider: divides the selected input by 1 to 32
// assumes edge_any pulses once per input transition
module ref_divider
  import clk_src_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // divide factor minus one
  input wire logic [DIV_W-1:0] div_field,
  // edge events
  ref_edge_if.div edges,
  // divided reference level
  output logic ref_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic clk;
  } div_s;

  div_s r;
  div_s n;

  // toggle after field+1 transitions: 50% duty for any factor
  always_comb begin
    n = r;
    if (edges.edge_any) begin
      if (r.cnt >= div_field) begin
        n.cnt = '0;
        n.clk = ~r.clk;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ref_out = r.clk;

endmodule

// >>> verilog/clk_source_ctrl.sv
// input clock source control: strap, oscillator sleep, stabilization,
// bypass or pll selection and prescale, with an axi4-lite register slave
// assumes the oscillator, external pin, strap and idle flag are asynchronous
//
// The AXI4-Lite register port and the address map are this design's own decisions.
module clk_source_ctrl
#(
  parameter int unsigned STAB_CYCLES = clk_src_pkg::STAB_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins and clock generator inputs
  input wire logic source_strap_pin,
  input wire logic oscillator_output_clock,
  input wire logic external_clock_pin,
  input wire logic generator_idle_flag,
  // clock path controls
  output logic oscillator_power_down,
  output logic input_source_select_bit,
  output logic pll_mode,
  output logic [clk_src_pkg::MULT_W-1:0] frequency_multiplier,
  output logic pll_reference_clock,
  output logic bypass_clock,
  output logic clock_stable,
  output logic program_release,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import clk_src_pkg::*;

  typedef struct packed {
    src_state_e state;
    logic [1:0] strap_wait;
    // synchronisers
    logic strap_s1;
    logic strap_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic idle_s1;
    logic idle_s2;
    // software controls
    logic pll_sel;
    logic sleep;
    logic [DIV_W-1:0] div_field;
    logic [MULT_W-1:0] mult_field;
    // block state
    logic src_sel;
    logic osc_down;
    logic release_run;
    logic reload;
    logic stable;
    logic bypass_clk;
    logic ref_clk;
    // write channel
    logic awready;
    logic aw_got;
    logic [7:0] aw_addr;
    logic wready;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    // read channel
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctrl_s;

  ctrl_s r;
  ctrl_s n;
  logic sel_lvl;
  logic sel_prev;
  logic div_out;
  logic [7:0] wa;
  logic [7:0] ra;

  ref_edge_if edges ();

  // edges of the selected input, seen after synchronisation
  assign sel_lvl = r.src_sel ? r.ext_s2 : r.osc_s2;
  assign sel_prev = r.src_sel ? r.ext_s3 : r.osc_s3;
  assign edges.edge_rise = sel_lvl & ~sel_prev;
  assign edges.edge_any = sel_lvl ^ sel_prev;
  assign edges.reload = r.reload;
  // write offset from the address taken this cycle or the one held earlier;
  // read from registered state only, so no loop through the next-state copy
  always_comb begin
    if (s_axi_awvalid && r.awready) begin
      wa = {s_axi_awaddr[7:2], 2'h0};
    end else begin
      wa = {r.aw_addr[7:2], 2'h0};
    end
  end
  assign ra = {s_axi_araddr[7:2], 2'h0};

  stab_counter #(
    .STAB_CYCLES(STAB_CYCLES)
  ) u_stab (
    .core_clk(core_clk),
    .resetn(resetn),
    .edges(edges.stab)
  );

  ref_divider u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .div_field(r.div_field),
    .edges(edges.div),
    .ref_out(div_out)
  );

  // next state of the whole block
  always_comb begin
    n = r;
    n.reload = 1'b0;

    // two-flop synchronisers, third stage only for edge detection
    n.strap_s1 = source_strap_pin;
    n.strap_s2 = r.strap_s1;
    n.osc_s1 = oscillator_output_clock;
    n.osc_s2 = r.osc_s1;
    n.osc_s3 = r.osc_s2;
    n.ext_s1 = external_clock_pin;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    n.idle_s1 = generator_idle_flag;
    n.idle_s2 = r.idle_s1;

    // clock path outputs
    n.stable = edges.stable;
    n.bypass_clk = sel_lvl;
    n.ref_clk = div_out;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // every field sits in byte lane 0
      if (wa == CTRL_OFS) begin
        if (n.wstrb[0]) begin
          n.pll_sel = n.wdata[CTRL_PLL_BIT];
          n.sleep = n.wdata[CTRL_SLEEP_BIT];
        end
      end else if (wa == DIV_OFS) begin
        if (n.wstrb[0]) begin
          n.div_field = n.wdata[DIV_W-1:0];
        end
      end else if (wa == MULT_OFS) begin
        if (n.wstrb[0]) begin
          // factors below two are raised to the minimum
          if (n.wdata[MULT_W-1:0] < MULT_MIN) begin
            n.mult_field = MULT_MIN;
          end else begin
            n.mult_field = n.wdata[MULT_W-1:0];
          end
        end
      end else if (wa != STAT_OFS) begin
        n.bresp = RESP_SLVERR;
      end
    end
    n.awready = ~n.aw_got;
    n.wready = ~n.w_got;

    // read channel: one word answered the cycle after it is taken
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      if (ra == CTRL_OFS) begin
        n.rdata[CTRL_PLL_BIT] = r.pll_sel;
        n.rdata[CTRL_SLEEP_BIT] = r.sleep;
      end else if (ra == DIV_OFS) begin
        n.rdata[DIV_W-1:0] = r.div_field;
      end else if (ra == MULT_OFS) begin
        n.rdata[MULT_W-1:0] = r.mult_field;
      end else if (ra == STAT_OFS) begin
        n.rdata[STAT_SRC_BIT] = r.src_sel;
        n.rdata[STAT_STABLE_BIT] = r.stable;
        n.rdata[STAT_RUN_BIT] = r.release_run;
        n.rdata[STAT_DOWN_BIT] = r.osc_down;
        n.rdata[STAT_IDLE_BIT] = r.idle_s2;
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    n.arready = ~n.rvalid;

    // source, sleep and program release sequencing
    unique case (r.state)
      ST_STRAP: begin
        // let the strap pass its synchroniser before capture
        if (r.strap_wait == STRAP_WAIT) begin
          n.src_sel = r.strap_s2;
          n.state = ST_BOOT;
        end else begin
          n.strap_wait = r.strap_wait + 1'b1;
        end
      end
      ST_BOOT: begin
        // external source skips the oscillator wait
        if (r.src_sel || edges.stable) begin
          n.release_run = 1'b1;
          n.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (r.sleep && r.src_sel) begin
          n.osc_down = 1'b1;
          n.state = ST_ASLEEP;
        end else if (r.sleep && r.idle_s2) begin
          n.osc_down = 1'b1;
          n.release_run = 1'b0;
          n.state = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (!r.sleep) begin
          n.osc_down = 1'b0;
          n.reload = 1'b1;
          n.state = ST_RELOAD;
        end
      end
      ST_RELOAD: begin
        // counter sees the reload now; stable drops next cycle
        n.state = ST_WAKE;
      end
      ST_WAKE: begin
        if (r.src_sel) begin
          n.state = ST_RUN;
        end else if (edges.stable) begin
          n.release_run = 1'b1;
          n.state = ST_RUN;
        end
      end
      // two codes of the state field are unused; recover through strap capture
      default: begin
        n.state = ST_STRAP;
      end
    endcase
  end

  // single state register; pll bypassed after reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.state <= ST_STRAP;
      r.div_field <= DIV_RST;
      r.mult_field <= MULT_RST;
      r.pll_sel <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign oscillator_power_down = r.osc_down;
  assign input_source_select_bit = r.src_sel;
  assign pll_mode = r.pll_sel;
  assign frequency_multiplier = r.mult_field;
  assign pll_reference_clock = r.ref_clk;
  assign bypass_clock = r.bypass_clk;
  assign clock_stable = r.stable;
  assign program_release = r.release_run;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;

endmodule

// >>> verif/clk_source_ctrl_assertions.sv
// checker for the input clock source controller ports
// assumes it is bound onto clk_source_ctrl, one clock domain
module clk_source_ctrl_assertions #(
  parameter int unsigned STAB_CYCLES = clk_src_pkg::STAB_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // clock path
  input wire logic generator_idle_flag,
  input wire logic oscillator_power_down,
  input wire logic input_source_select_bit,
  input wire logic pll_mode,
  input wire logic clock_stable,
  input wire logic program_release,
  // register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready
);
  import clk_src_pkg::*;
  logic ctrl_wr;
  int unsigned low_cnt_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // control register write taken at this edge
  assign ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == CTRL_OFS;

  // cycles spent with the clock not yet stable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= 0;
    end else if (clock_stable) begin
      low_cnt_r <= 0;
    end else begin
      low_cnt_r <= low_cnt_r + 1;
    end
  end

  AST_REL_GATED: assert property (!clock_stable && !input_source_select_bit |-> !program_release)
    else $error("release while counting");
  AST_BYPASS_RESET: assert property ($past(!resetn) |-> !pll_mode)
    else $error("pll selected after reset");
  AST_PLL_SELECT: assert property ($changed(pll_mode) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("mode changed without write");
  AST_EXT_SLEEP: assert property (ctrl_wr && s_axi_wdata[1] && input_source_select_bit
    |-> ##[1:4] oscillator_power_down) else $error("external sleep late");
  AST_OSC_IDLE: assert property ($rose(oscillator_power_down) && !input_source_select_bit
    |-> $past(generator_idle_flag, 3)) else $error("sleep without idle");
  AST_WAKE_RELOAD: assert property ($fell(oscillator_power_down) |-> ##[0:3] !clock_stable)
    else $error("no reload on wake");
  AST_STAB_LEN: assert property ($rose(clock_stable) |-> low_cnt_r >= STAB_CYCLES)
    else $error("stable too early");
  AST_RUN_AFTER: assert property ($rose(clock_stable) && !input_source_select_bit
    |-> ##[1:4] program_release) else $error("release late");

  // main scenarios seen
  cover property ($rose(program_release));
  cover property ($rose(oscillator_power_down));
  cover property ($rose(pll_mode));
endmodule

bind clk_source_ctrl clk_source_ctrl_assertions #(.STAB_CYCLES(STAB_CYCLES)) chk (.*);

// >>> verif/clock_source_model.sv
// partner model: crystal oscillator and external clock source
// assumes the controller drives the oscillator power-down level
module clock_source_model #(
  parameter int OSC_HALF = 50,
  parameter int EXT_HALF = 40
) (
  // power-down level
  input wire logic osc_down,
  // clocks toward the controller
  output logic osc_clk,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // 10 mhz oscillator, stands still at 0 while powered down
  initial begin
    osc_clk = 1'b0;
    forever begin
      #(OSC_HALF);
      osc_clk = osc_down ? 1'b0 : ~osc_clk;
    end
  end

  // 12.5 mhz free-running external clock
  initial begin
    ext_clk = 1'b0;
    forever #(EXT_HALF) ext_clk = ~ext_clk;
  end
endmodule

// >>> verif/osc_pll_clock_source_control_tb_top.sv
// self-checking bench for the input clock source controller
// assumes a 40 mhz core clock and the clock source model
module osc_pll_clock_source_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_src_pkg::*;
  localparam int STAB = 8;
  logic core_clk, resetn, source_strap_pin, oscillator_output_clock, external_clock_pin;
  logic generator_idle_flag, oscillator_power_down, input_source_select_bit, pll_mode;
  logic pll_reference_clock, bypass_clock, clock_stable, program_release;
  logic [3:0] frequency_multiplier, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails, checks, n;

  clk_source_ctrl #(.STAB_CYCLES(STAB)) DUT (.*);
  clock_source_model src (.osc_down(oscillator_power_down), .osc_clk(oscillator_output_clock),
    .ext_clk(external_clock_pin));

  // core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end while (!(ta && tw));
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic do_reset(input logic strap);
    resetn <= 1'b0;
    source_strap_pin <= strap;
    cyc(20);
    resetn <= 1'b1;
  endtask

  task automatic wait_rel();
    n = 0;
    while (program_release !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic sc_boot_osc();
    do_reset(1'b0);
    wait_rel();
    check("osc boot wait", 32'(n >= 4 * STAB - 4), 32'h1);
    rd(STAT_OFS);
    check("status", d, 32'h6);
    check("src osc", 32'(input_source_select_bit), 32'h0);
    rd(MULT_OFS);
    check("mult reset", d, 32'h2);
    rd(CTRL_OFS);
    check("ctrl reset", d, 32'h0);
    check("bypass", 32'(pll_mode), 32'h0);
  endtask

  task automatic sc_regs();
    int dv[3] = '{0, 3, 31};
    int k, e;
    logic p;
    wr(MULT_OFS, 32'h1);
    rd(MULT_OFS);
    check("mult clamp", d, 32'h2);
    wr(MULT_OFS, 32'hF);
    check("mult out", 32'(frequency_multiplier), 32'hF);
    wr(8'h10, 32'h1);
    check("unmapped wr", 32'(r), 32'(RESP_SLVERR));
    rd(8'h10);
    check("unmapped rd", {d[29:0], r}, 32'(RESP_SLVERR));
    foreach (dv[i]) begin
      wr(DIV_OFS, dv[i]);
      cyc(80);
      k = 0;
      p = pll_reference_clock;
      repeat (640) begin
        @(posedge core_clk);
        k += int'(pll_reference_clock && !p);
        p = pll_reference_clock;
      end
      e = 160 / (dv[i] + 1);
      check("ref divide", 32'(k + 1 >= e && k <= e + 1), 32'h1);
    end
  endtask

  task automatic sc_osc_sleep();
    wr(CTRL_OFS, 32'h2);
    cyc(10);
    check("down no idle", 32'(oscillator_power_down), 32'h0);
    generator_idle_flag <= 1'b1;
    cyc(8);
    check("down idle", 32'(oscillator_power_down), 32'h1);
    check("held", 32'(program_release), 32'h0);
    generator_idle_flag <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    cyc(3);
    check("reload", 32'(clock_stable), 32'h0);
    wait_rel();
    check("wake wait", 32'(n >= 2 * STAB && n < 400), 32'h1);
  endtask

  task automatic sc_ext();
    int k;
    logic p;
    do_reset(1'b1);
    wait_rel();
    check("ext boot wait", 32'(n <= 12), 32'h1);
    rd(STAT_OFS);
    check("ext source", 32'(d[STAT_SRC_BIT]), 32'h1);
    check("src ext", 32'(input_source_select_bit), 32'h1);
    // bypass clock follows the 12.5 mhz pin: 50 rises in 160 cycles
    k = 0;
    p = bypass_clock;
    repeat (160) begin
      @(posedge core_clk);
      k += int'(bypass_clock && !p);
      p = bypass_clock;
    end
    check("bypass follows pin", 32'(k >= 49 && k <= 51), 32'h1);
    // 12.5 mhz reference times 15 keeps the pll inside its ranges
    // no group dividers here, so core and peripheral limits hold too
    wr(DIV_OFS, 32'h0);
    wr(MULT_OFS, 32'hF);
    wr(CTRL_OFS, 32'h1);
    check("pll on", 32'(pll_mode), 32'h1);
    wr(CTRL_OFS, 32'h2);
    cyc(4);
    check("ext down", 32'(oscillator_power_down), 32'h1);
    check("ext runs", 32'(program_release), 32'h1);
    check("pll off", 32'(pll_mode), 32'h0);
  endtask

  // stimulus and verdict
  initial begin
    {resetn, source_strap_pin, generator_idle_flag, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    checks = 0;
    sc_boot_osc();
    sc_regs();
    sc_osc_sleep();
    sc_ext();
    stop_test();
  end

  // hang guard
  initial begin
    #500000;
    fails++;
    stop_test();
  end
endmodule
